// ==== hw/alarm_pkg.sv ====
// Constants and types shared by the alarm and loop supervisor.
// Assumes one 200 MHz clock and signed fixed-point process units.
package alarm_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int PV_W     = 16;
    localparam int PCT_W    = 7;
    localparam int LB_W     = 8;
    localparam int NUM_OUT  = 4;
    localparam int NUM_ALM  = 2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam longint CLK_HZ       = 200_000_000;
    localparam longint LB_MINUTE_S  = 60;
    localparam longint LB_MINUTE_CYCLES = LB_MINUTE_S * CLK_HZ;
    localparam int     PWM_STEP_CYCLES  = 1000;
    localparam int     LB_REACT_DELTA   = 1;

    // ------------------------------------------------------------
    // Values
    // ------------------------------------------------------------
    localparam logic [PCT_W-1:0] PCT_ZERO = 7'h00;
    localparam logic [PCT_W-1:0] PCT_FULL = 7'h64;
    localparam logic [PCT_W-1:0] PWM_LAST = 7'h63;
    localparam logic [PV_W-1:0]  PB_ZERO  = 16'h0000;
    localparam logic [LB_W-1:0]  LB_OFF   = 8'h00;
    localparam logic signed [PV_W-1:0] PV_MAX = 16'sh7FFF;
    localparam logic signed [PV_W-1:0] PV_MIN = -16'sh7FFF - 16'sh0001;

    // ------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        ALM_UNUSED,
        ABSOLUTE_LOW_MODE,
        ABSOLUTE_HIGH_MODE,
        DEVIATION_MODE,
        DEVIATION_LOW_MODE,
        DEVIATION_HIGH_MODE,
        SENSOR_BREAK_MODE
    } alarm_mode_t;

    typedef enum logic [2:0]
    {
        CH_UNUSED,
        CH_CONTROL,
        CH_ALARM_ONE,
        CH_ALARM_TWO,
        CH_ALARM_EITHER,
        CH_LOOP_BREAK
    } chan_func_t;

endpackage : alarm_pkg

// ==== hw/alarm_loop_supervisor.sv ====
// Alarm evaluation, loop-break timing, safe output and channel routing.
// Inputs are synchronous to clk; the control algorithm lies outside.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Two independent alarms, each routable to any output channel.
// - Channels carry control, alarm one, alarm two, either alarm, loop break.
// - An unused alarm never asserts.
// - Absolute low: asserts while value below own setpoint.
// - Absolute high: asserts while value above own setpoint.
// - Deviation modes: alarm setpoint is signed offset from control setpoint.
// - Deviation low: asserts below control setpoint plus signed offset.
// - Deviation high: asserts above control setpoint plus signed offset.
// - Sensor break mode asserts whenever the input reports a fault.
// - Absolute high and both deviation-high kinds also assert on fault.
// - Initial blocking hides a startup alarm until first seen false.
// - Initial blocking never applies to sensor break mode.
// - During a fault control is forced to safe percent until cleared.
// - Safe percent is 0 or 100 in on/off, 0 to 100 in PID.
// - Zero proportional band means on/off control, otherwise PID.
// - Loop break raised if value unchanged an interval after control action.
// - A loop-break channel is asserted while the event is present.
// - Zero loop-break interval disables supervision entirely.
// - User offset is added to the measured value before use.
module alarm_loop_supervisor
    import alarm_pkg::*;
#(
    parameter longint MINUTE_CYCLES = LB_MINUTE_CYCLES,
    parameter int     PWM_STEP      = PWM_STEP_CYCLES
)
(
    input  wire  logic                    clk,
    input  wire  logic                    rst,
    input  wire  logic signed [PV_W-1:0]  measured_value,
    input  wire  logic signed [PV_W-1:0]  offset_correction,
    input  wire  logic                    sensor_fault,
    input  wire  logic signed [PV_W-1:0]  control_setpoint,
    input  wire  logic signed [PV_W-1:0]  alarm_one_setpoint,
    input  wire  logic signed [PV_W-1:0]  alarm_two_setpoint,
    input  wire  alarm_mode_t             alarm_one_mode,
    input  wire  alarm_mode_t             alarm_two_mode,
    input  wire  logic                    alarm_one_block_en,
    input  wire  logic                    alarm_two_block_en,
    input  wire  logic [PV_W-1:0]         proportional_band,
    input  wire  logic [PCT_W-1:0]        safe_output_percent,
    input  wire  logic [PCT_W-1:0]        control_percent_in,
    input  wire  logic                    control_on_in,
    input  wire  logic [LB_W-1:0]         loop_break_interval,
    input  wire  chan_func_t              chan_func [NUM_OUT],
    output logic signed [PV_W-1:0]        process_value,
    output logic                          alarm_one,
    output logic                          alarm_two,
    output logic                          loop_break_event,
    output logic                          on_off_mode,
    output logic [PCT_W-1:0]              control_percent,
    output logic [NUM_OUT-1:0]            chan_out
);

    // ------------------------------------------------------------
    // Alarm condition
    // ------------------------------------------------------------
    function automatic logic alarm_cond(
        input alarm_mode_t             mode,
        input logic signed [PV_W-1:0]  pv, sp, asp,
        input logic                    fault
    );
        logic signed [PV_W+1:0] v, a, up, dn;
        logic                   c;
        v  = (PV_W+2)'(pv);
        a  = (PV_W+2)'(asp);
        up = (PV_W+2)'(sp) + a;
        dn = (PV_W+2)'(sp) - a;
        unique case (mode)
            ALM_UNUSED:          c = 1'b0;
            ABSOLUTE_LOW_MODE:   c = v < a;
            ABSOLUTE_HIGH_MODE:  c = (v > a) || fault;
            DEVIATION_MODE:
                c = fault || ((a >= 0) ? (v < dn || v > up)
                                       : (v > up && v < dn));
            DEVIATION_LOW_MODE:  c = v < up;
            DEVIATION_HIGH_MODE: c = (v > up) || fault;
            SENSOR_BREAK_MODE:   c = fault;
            default:             c = 1'b0;
        endcase
        return c;
    endfunction : alarm_cond

    // ------------------------------------------------------------
    // Channel selection
    // ------------------------------------------------------------
    function automatic logic chan_drive(
        input chan_func_t f,
        input logic       ctl, a1, a2, lb
    );
        logic d;
        unique case (f)
            CH_UNUSED:       d = 1'b0;
            CH_CONTROL:      d = ctl;
            CH_ALARM_ONE:    d = a1;
            CH_ALARM_TWO:    d = a2;
            CH_ALARM_EITHER: d = a1 | a2;
            CH_LOOP_BREAK:   d = lb;
            default:         d = 1'b0;
        endcase
        return d;
    endfunction : chan_drive

    // ------------------------------------------------------------
    // Offset correction
    // ------------------------------------------------------------
    logic signed [PV_W:0]   pv_sum;
    logic signed [PV_W-1:0] pv_next;

    assign pv_sum  = (PV_W+1)'(measured_value) + (PV_W+1)'(offset_correction);
    assign pv_next = (pv_sum > (PV_W+1)'(PV_MAX)) ? PV_MAX :
                     (pv_sum < (PV_W+1)'(PV_MIN)) ? PV_MIN :
                     pv_sum[PV_W-1:0];

    always_ff @(posedge clk)
    begin
        process_value <= rst ? '0 : pv_next;
    end

    // ------------------------------------------------------------
    // Alarms with initial blocking
    // ------------------------------------------------------------
    alarm_mode_t            alm_mode  [NUM_ALM];
    logic signed [PV_W-1:0] alm_sp    [NUM_ALM];
    logic                   alm_blk_en[NUM_ALM];
    logic [NUM_ALM-1:0]     alm_cond, alm_next, alm_reg, blk_next, blk_reg;

    assign alm_mode   = '{alarm_one_mode, alarm_two_mode};
    assign alm_sp     = '{alarm_one_setpoint, alarm_two_setpoint};
    assign alm_blk_en = '{alarm_one_block_en, alarm_two_block_en};

    for (genvar i = 0; i < NUM_ALM; i++)
    begin : g_alarm
        assign alm_cond[i] = alarm_cond(alm_mode[i], process_value,
                                        control_setpoint, alm_sp[i],
                                        sensor_fault);
        assign alm_next[i] = alm_cond[i] &&
                             !(blk_reg[i] && alm_blk_en[i] &&
                               alm_mode[i] != SENSOR_BREAK_MODE);
        assign blk_next[i] = blk_reg[i] && alm_cond[i];
    end

    always_ff @(posedge clk)
    begin
        alm_reg <= rst ? '0 : alm_next;
        blk_reg <= rst ? '1 : blk_next;
    end

    assign alarm_one = alm_reg[0];
    assign alarm_two = alm_reg[1];

    // ------------------------------------------------------------
    // Control output and safe value
    // ------------------------------------------------------------
    logic                   on_off_next;
    logic [PCT_W-1:0]       safe_eff;
    logic [PCT_W-1:0]       ctl_in_eff;
    logic [PCT_W-1:0]       pct_next;
    logic [PCT_W-1:0]       pwm_phase_reg;
    logic [31:0]            pwm_pre_reg;
    logic                   pwm_tick, ctl_level_next, ctl_level_reg;

    assign on_off_next = (proportional_band == PB_ZERO);
    assign safe_eff    = on_off_next ?
                         ((safe_output_percent == PCT_ZERO) ? PCT_ZERO
                                                            : PCT_FULL) :
                         ((safe_output_percent > PCT_FULL) ? PCT_FULL
                                                           : safe_output_percent);
    assign ctl_in_eff  = (control_percent_in > PCT_FULL) ? PCT_FULL
                                                         : control_percent_in;
    assign pct_next    = sensor_fault ? safe_eff : ctl_in_eff;
    assign pwm_tick    = (pwm_pre_reg == 32'(PWM_STEP - 1));
    assign ctl_level_next = on_off_mode ?
                            (sensor_fault ? (safe_eff != PCT_ZERO)
                                          : control_on_in) :
                            (pwm_phase_reg < control_percent);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            on_off_mode     <= 1'b1;
            control_percent <= PCT_ZERO;
            ctl_level_reg   <= 1'b0;
            pwm_pre_reg     <= '0;
            pwm_phase_reg   <= PCT_ZERO;
        end
        else
        begin
            on_off_mode     <= on_off_next;
            control_percent <= pct_next;
            ctl_level_reg   <= ctl_level_next;
            pwm_pre_reg     <= pwm_tick ? '0 : pwm_pre_reg + 32'd1;
            if (pwm_tick)
                pwm_phase_reg <= (pwm_phase_reg == PWM_LAST) ? PCT_ZERO
                                 : pwm_phase_reg + 7'h01;
        end
    end

    // ------------------------------------------------------------
    // Loop-break supervision
    // ------------------------------------------------------------
    logic                   lb_run_reg;
    logic [63:0]            lb_pre_reg;
    logic [LB_W-1:0]        lb_min_reg;
    logic signed [PV_W-1:0] lb_start_reg;
    logic signed [PV_W:0]   lb_diff;
    logic                   lb_reacted, lb_action, lb_minute, lb_expire;

    assign lb_diff    = (PV_W+1)'(process_value) - (PV_W+1)'(lb_start_reg);
    assign lb_reacted = (lb_diff >= (PV_W+1)'(LB_REACT_DELTA)) ||
                        (lb_diff <= -(PV_W+1)'(LB_REACT_DELTA));
    assign lb_action  = (pct_next != control_percent) ||
                        (on_off_mode && ctl_level_next != ctl_level_reg);
    assign lb_minute  = lb_run_reg && (lb_pre_reg == 64'(MINUTE_CYCLES - 1));
    assign lb_expire  = lb_minute && (lb_min_reg + 8'h01 == loop_break_interval);

    always_ff @(posedge clk)
    begin
        if (rst || loop_break_interval == LB_OFF)
        begin
            lb_run_reg       <= 1'b0;
            lb_pre_reg       <= '0;
            lb_min_reg       <= LB_OFF;
            lb_start_reg     <= '0;
            loop_break_event <= 1'b0;
        end
        else if (lb_action)
        begin
            lb_run_reg   <= 1'b1;
            lb_pre_reg   <= '0;
            lb_min_reg   <= LB_OFF;
            lb_start_reg <= process_value;
        end
        else if (lb_run_reg)
        begin
            if (lb_reacted)
                lb_run_reg <= 1'b0;
            else if (lb_expire)
            begin
                lb_run_reg       <= 1'b0;
                loop_break_event <= 1'b1;
            end
            lb_pre_reg <= lb_minute ? '0 : lb_pre_reg + 64'd1;
            if (lb_minute)
                lb_min_reg <= lb_min_reg + 8'h01;
        end
        else if (loop_break_event && lb_reacted)
            loop_break_event <= 1'b0;
    end

    // ------------------------------------------------------------
    // Channel routing
    // ------------------------------------------------------------
    logic [NUM_OUT-1:0] chan_next;

    for (genvar k = 0; k < NUM_OUT; k++)
    begin : g_chan
        assign chan_next[k] = chan_drive(chan_func[k], ctl_level_reg,
                                         alm_reg[0], alm_reg[1],
                                         loop_break_event);
    end

    always_ff @(posedge clk)
    begin
        chan_out <= rst ? '0 : chan_next;
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_unused_silent;
        alarm_one_mode == ALM_UNUSED |=> !alarm_one;
    endproperty
    a_unused_silent: assert property (p_unused_silent)
        else $error("unused alarm asserted");
    property p_break_immediate;
        alarm_two_mode == SENSOR_BREAK_MODE && sensor_fault |=> alarm_two;
    endproperty
    a_break_immediate: assert property (p_break_immediate)
        else $error("sensor break alarm not raised");
    property p_abs_low;
        alarm_one_mode == ABSOLUTE_LOW_MODE && !alarm_one_block_en &&
        process_value < alarm_one_setpoint |=> alarm_one;
    endproperty
    a_abs_low: assert property (p_abs_low)
        else $error("absolute low alarm missing");
    property p_high_on_fault;
        alarm_one_mode == ABSOLUTE_HIGH_MODE && !alarm_one_block_en &&
        sensor_fault |=> alarm_one;
    endproperty
    a_high_on_fault: assert property (p_high_on_fault)
        else $error("high alarm ignores sensor fault");
    property p_safe_forced;
        sensor_fault |=> control_percent == $past(safe_eff);
    endproperty
    a_safe_forced: assert property (p_safe_forced)
        else $error("safe percentage not applied");
    property p_onoff_safe;
        sensor_fault && proportional_band == PB_ZERO |=>
            control_percent == PCT_ZERO || control_percent == PCT_FULL;
    endproperty
    a_onoff_safe: assert property (p_onoff_safe)
        else $error("on/off safe value not 0 or 100");
    property p_band_mode;
        proportional_band == PB_ZERO |=> on_off_mode;
    endproperty
    a_band_mode: assert property (p_band_mode)
        else $error("on/off mode not selected");
    property p_lb_disabled;
        loop_break_interval == LB_OFF |=> !loop_break_event;
    endproperty
    a_lb_disabled: assert property (p_lb_disabled)
        else $error("loop break raised while disabled");
    property p_lb_route;
        chan_func[0] == CH_LOOP_BREAK |=> chan_out[0] == $past(loop_break_event);
    endproperty
    a_lb_route: assert property (p_lb_route)
        else $error("loop break channel mismatch");
    property p_offset;
        pv_sum <= (PV_W+1)'(PV_MAX) && pv_sum >= (PV_W+1)'(PV_MIN) |=>
            process_value == $past(measured_value) + $past(offset_correction);
    endproperty
    a_offset: assert property (p_offset)
        else $error("offset not applied");

endmodule : alarm_loop_supervisor

`default_nettype wire

// ==== sim/sensor_front_end.sv ====
// Far-side model: sensor measurement path feeding the supervisor.
// Assumes the bench gives a target value and a fault request.
`timescale 1ns/1ps
`default_nettype none
module sensor_front_end
    import alarm_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic signed [PV_W-1:0] target,
    input  wire logic                   fault_req,
    output var  logic signed [PV_W-1:0] measured_value = 16'sh0000,
    output var  logic                   sensor_fault = 1'b0
);
    // Broken sensor shows a value that changes every cycle
    always @(posedge clk)
    begin
        sensor_fault   <= fault_req;
        measured_value <= fault_req ? ~measured_value : target;
    end
endmodule : sensor_front_end
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench: cycle model of the supervisor, random stimulus.
// Assumes alarm_pkg and the supervisor are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb
    import alarm_pkg::*;
    ;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic signed [PV_W-1:0] target = '0, offs = '0, csp = '0;
    logic signed [PV_W-1:0] sp1 = '0, sp2 = '0;
    logic fault_req = 1'b0, blk1 = 1'b0, blk2 = 1'b0, on_in = 1'b0;
    alarm_mode_t m1 = ALM_UNUSED, m2 = ALM_UNUSED;
    logic [PV_W-1:0] band = '0;
    logic [PCT_W-1:0] safe = '0, cpin = '0;
    logic [LB_W-1:0] lbi = '0;
    chan_func_t cf [NUM_OUT];
    wire logic signed [PV_W-1:0] meas, pv;
    wire logic sfault, a1, a2, lbe, oom;
    wire logic [PCT_W-1:0] cp;
    wire logic [NUM_OUT-1:0] ch;
    int num_errors = 0, num_checks = 0, cycles = 0;
    bit [31:0] st = 32'hE55F;
    localparam int SIM_PWM_STEP = 2;
    int pv_m, cp_m, pre_m, ph_m;
    bit am [2], blk_m [2];
    bit ctl_m, oo_m, valid = 0;
    bit [NUM_OUT-1:0] ch_m;

    always #2.5 clk = ~clk;

    sensor_front_end u_sensor_front_end (.clk(clk), .target(target),
        .fault_req(fault_req), .measured_value(meas), .sensor_fault(sfault));

    alarm_loop_supervisor #(.MINUTE_CYCLES(10), .PWM_STEP(SIM_PWM_STEP))
    u_alarm_loop_supervisor (.clk(clk), .rst(rst), .measured_value(meas),
        .offset_correction(offs), .sensor_fault(sfault),
        .control_setpoint(csp), .alarm_one_setpoint(sp1),
        .alarm_two_setpoint(sp2), .alarm_one_mode(m1), .alarm_two_mode(m2),
        .alarm_one_block_en(blk1), .alarm_two_block_en(blk2),
        .proportional_band(band), .safe_output_percent(safe),
        .control_percent_in(cpin), .control_on_in(on_in),
        .loop_break_interval(lbi), .chan_func(cf), .process_value(pv),
        .alarm_one(a1), .alarm_two(a2), .loop_break_event(lbe),
        .on_off_mode(oom), .control_percent(cp), .chan_out(ch));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic int unsigned rnd();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction : rnd

    function automatic int lim(int x);
        return x > 100 ? 100 : x;
    endfunction : lim

    task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %0h seen %0h", n, exp, seen);
        end
    endtask : check

    task automatic stop_test();
        if (num_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    function automatic bit cond(alarm_mode_t m, int v, int s, int a, bit f);
        case (m)
            ABSOLUTE_LOW_MODE:   return v < a;
            ABSOLUTE_HIGH_MODE:  return v > a || f;
            DEVIATION_MODE:      return f || (a >= 0 ? (v < s-a || v > s+a)
                                     : (v > s+a && v < s-a));
            DEVIATION_LOW_MODE:  return v < s+a;
            DEVIATION_HIGH_MODE: return v > s+a || f;
            SENSOR_BREAK_MODE:   return f;
            default:             return 0;
        endcase
    endfunction : cond

    task automatic upd(int i, alarm_mode_t m, int a, bit en);
        bit c;
        c = cond(m, pv_m, int'(csp), a, sfault);
        am[i] = c && !(blk_m[i] && en && m != SENSOR_BREAK_MODE);
        if (!c)
            blk_m[i] = 0;
    endtask : upd

    // ------------------------------------------------------------
    // Model and compare at every edge
    // ------------------------------------------------------------
    always @(posedge clk)
    begin : model
        int s;
        if (valid)
        begin
            check("process_value", pv, pv_m);
            check("alarm_one", a1, am[0]);
            check("alarm_two", a2, am[1]);
            check("on_off_mode", oom, oo_m);
            check("control_percent", cp, cp_m);
            for (int k = 0; k < NUM_OUT; k++)
                if (!(cf[k] == CH_LOOP_BREAK && lbi != LB_OFF))
                    check("chan_out", ch[k], ch_m[k]);
            if (lbi == LB_OFF)
                check("loop_break_event", lbe, 0);
        end
        if (rst)
        begin
            pv_m = 0; cp_m = 0; am = '{0, 0}; blk_m = '{1, 1};
            ctl_m = 0; oo_m = 1; pre_m = 0; ph_m = 0; ch_m = '0; valid = 1;
        end
        else
        begin
            for (int k = 0; k < NUM_OUT; k++)
                ch_m[k] = cf[k] == CH_CONTROL ? ctl_m
                        : cf[k] == CH_ALARM_ONE ? am[0]
                        : cf[k] == CH_ALARM_TWO ? am[1]
                        : cf[k] == CH_ALARM_EITHER ? am[0] | am[1] : 0;
            upd(0, m1, int'(sp1), blk1);
            upd(1, m2, int'(sp2), blk2);
            ctl_m = oo_m ? (sfault ? safe != 0 : on_in) : ph_m < cp_m;
            if (pre_m == SIM_PWM_STEP - 1)
                ph_m = ph_m == int'(PWM_LAST) ? 0 : ph_m + 1;
            pre_m = pre_m == SIM_PWM_STEP - 1 ? 0 : pre_m + 1;
            cp_m = !sfault ? lim(int'(cpin)) : band != PB_ZERO
                 ? lim(int'(safe)) : (safe != 0 ? 100 : 0);
            oo_m = band == PB_ZERO;
            s = int'(meas) + int'(offs);
            pv_m = s > 32767 ? 32767 : (s < -32768 ? -32768 : s);
        end
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic segment(int n, bit hi);
        rst <= 1'b1;
        lbi <= LB_OFF;
        m1 <= alarm_mode_t'(rnd() % 7);
        m2 <= alarm_mode_t'(rnd() % 7);
        blk1 <= rnd() % 2;
        blk2 <= rnd() % 2;
        band <= (rnd() % 2) ? PB_ZERO : 16'h0032;
        csp <= 16'(int'(rnd() % 21) - 10);
        sp1 <= 16'(int'(rnd() % 41) - 20);
        sp2 <= 16'(int'(rnd() % 41) - 20);
        safe <= 7'(rnd());
        for (int k = 0; k < NUM_OUT; k++)
            cf[k] <= chan_func_t'(rnd() % 6);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (n)
        begin
            target <= (hi ? 16'sh7F00 : 16'sh0000) + 16'(int'(rnd() % 81) - 40);
            offs <= hi ? 16'sh0200 : 16'(int'(rnd() % 11) - 5);
            fault_req <= rnd() % 8 == 0;
            cpin <= 7'(rnd());
            on_in <= rnd() % 2;
            @(posedge clk);
        end
    endtask : segment

    task automatic loop_break_case(logic [LB_W-1:0] n);
        rst <= 1'b1;
        lbi <= n;
        band <= 16'h0032;
        fault_req <= 1'b0;
        cf[0] <= CH_LOOP_BREAK;
        target <= 16'sh0010;
        offs <= 16'sh0000;
        cpin <= 7'h0A;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        cpin <= 7'h32;
        repeat (30) @(posedge clk);
        check("loop_break_event", lbe, n != LB_OFF);
        check("chan_out", ch[0], n != LB_OFF);
        target <= 16'sh0015;
        repeat (5) @(posedge clk);
        check("loop_break_event", lbe, 0);
    endtask : loop_break_case

    initial
    begin
        for (int k = 0; k < NUM_OUT; k++)
            cf[k] = CH_UNUSED;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 20; i++)
            segment(300, i == 5);
        loop_break_case(8'h02);
        loop_break_case(8'h00);
        stop_test();
    end
endmodule : tb
`default_nettype wire
